//--- hdl/mbr_defs.svh
/*
  Constants of the serial command frame handler: timing, codes, limits.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef MBR_DEFS_SVH
`define MBR_DEFS_SVH

`define MBR_CLK_NS    5
`define MBR_CHAR_NS   1145834
`define MBR_CHAR_CYC  ((`MBR_CHAR_NS + `MBR_CLK_NS - 1) / `MBR_CLK_NS)
`define MBR_GAP_HALFS 7
`define MBR_CRC_INIT  16'hffff
`define MBR_CRC_POLY  16'ha001
`define MBR_FN_RD     8'h03
`define MBR_FN_WR     8'h10
`define MBR_EXC_FLAG  8'h80
`define MBR_EC_FUNC   8'h01
`define MBR_EC_ADDR   8'h02
`define MBR_EC_DATA   8'h03
`define MBR_EC_OPER   8'h04
`define MBR_BCAST     8'h00
`define MBR_UNIT_MIN  8'h01
`define MBR_UNIT_MAX  8'h63
`define MBR_RD_MAX    16'h007d
`define MBR_WR_MAX    16'h007b
`define MBR_LOG_LO    16'h2000
`define MBR_LOG_HI    16'h2fff
`define MBR_RD_LEN    8'h08
`define MBR_WR_OVH    9'h009
`define MBR_WDAT_POS  9'h007

`endif

//--- hdl/mbr_pkg.sv
/*
  Types and the CRC step shared by both ends of the serial link.
  Assumes mbr_defs.svh is on the include path.
*/
`include "mbr_defs.svh"

package mbr_pkg;
  typedef logic [7:0]  mbr_byte_type;
  typedef logic [15:0] mbr_crc_type;

  typedef enum logic [2:0] {
    MBR_S_RX, MBR_S_CHK, MBR_S_WCHK, MBR_S_WR, MBR_S_RESP, MBR_S_FIN
  } mbr_sl_state_type;

  typedef enum logic [1:0] {
    MBR_M_IDLE, MBR_M_SEND, MBR_M_CRCL, MBR_M_CRCH
  } mbr_ms_state_type;

  function automatic mbr_crc_type mbr_crc_step(mbr_crc_type c,
                                               mbr_byte_type b);
    mbr_crc_type r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBR_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

//--- hdl/mbr_link_if.sv
/*
  Byte-level serial link between host master and slave handler.
  Assumes one shared clock; each strobe marks one character on the line.
*/
`timescale 1ns/1ps
`default_nettype none

interface mbr_link_if;
  logic       m2s_stb;
  logic [7:0] m2s_data;
  logic       m2s_err;
  logic       s2m_stb;
  logic [7:0] s2m_data;

  modport slave (input m2s_stb, m2s_data, m2s_err,
                 output s2m_stb, s2m_data);
  modport master (output m2s_stb, m2s_data, m2s_err,
                  input s2m_stb, s2m_data);
endinterface

`default_nettype wire

//--- hdl/mbr_slave.sv
/*
  Slave end: response FIFO and the command frame handler.
  Assumes a parameter store on the user side answering reads one cycle
  after par_rd and judging par_ok combinationally from par_addr/par_wdata.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mbr_defs.svh"

module mbr_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("mbr_fifo depth must be a power of two, at least 2");
  end
  logic [W-1:0] mem [D];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  wire          push = ce && in_valid && in_ready;
  wire          pop  = ce && out_valid && out_ready;

  assign in_ready  = (wp - rp) != (AW+1)'(D);
  assign out_valid = wp != rp;
  assign out_data  = mem[rp[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end
endmodule // mbr_fifo

module mbr_slave import mbr_pkg::*; #(
  parameter int CHAR_CYC   = `MBR_CHAR_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  input  wire logic   ce,
  mbr_link_if.slave   link,
  input  wire logic [7:0]  unit_no,
  input  wire logic        op_forbid,
  input  wire logic        log_run,
  input  wire logic [15:0] par_rdata,
  input  wire logic        par_ok,
  output logic [15:0]      par_addr,
  output logic [15:0]      par_wdata,
  output logic             par_rd,
  output logic             par_chk,
  output logic             par_wr,
  output logic             nvm_commit,
  output logic             cfg_reload
);
  localparam int T35 = (`MBR_GAP_HALFS * CHAR_CYC + 1) / 2;
  if (CHAR_CYC < 2 || T35 >= (1 << 24)) begin : g_bad_char
    $error("mbr_slave CHAR_CYC out of range");
  end

  mbr_sl_state_type st;
  mbr_byte_type rx_buf [256];
  logic [23:0]  gap;
  logic [7:0]   rx_len;
  logic         rx_ovf;
  logic         rx_bad;
  mbr_crc_type  rx_crc;
  mbr_crc_type  tx_crc;
  logic [7:0]   ecode;
  logic [7:0]   next_ecode;
  logic [7:0]   el;
  logic [8:0]   idx;
  logic [15:0]  rd_word;
  logic         word_ok;
  logic         rd_w;
  logic         rel_done;
  logic [23:0]  tx_cnt;
  mbr_byte_type rb;
  logic         rb_ok;
  logic         f_in_ready;
  logic         f_out_valid;
  mbr_byte_type f_out_data;

  wire [7:0]  f_adr = rx_buf[0];
  wire [7:0]  f_fn  = rx_buf[1];
  wire [15:0] f_sa  = {rx_buf[2], rx_buf[3]};
  wire [15:0] f_cnt = {rx_buf[4], rx_buf[5]};
  wire [7:0]  f_bc  = rx_buf[6];
  wire        bcast = f_adr == `MBR_BCAST;
  wire        is_rd = f_fn == `MBR_FN_RD;
  wire [16:0] f_end = {1'b0, f_sa} + {1'b0, f_cnt};
  wire [8:0]  rsp_len = (ecode != 8'h00) ? 9'd3 :
                        is_rd ? 9'd3 + {f_cnt[7:0], 1'b0} : 9'd6;
  wire        gap_full = gap == 24'(T35);
  wire        frame_end = st == MBR_S_RX && gap_full && rx_len != 8'h00;
  wire        unit_ok = unit_no >= `MBR_UNIT_MIN &&
                        unit_no <= `MBR_UNIT_MAX;
  wire        drop = rx_bad || rx_ovf || rx_len < 8'h04 ||
                     rx_crc != 16'h0000 ||
                     !(bcast || (unit_ok && f_adr == unit_no));
  wire        push = st == MBR_S_RESP && !bcast && rb_ok &&
                     idx < rsp_len + 9'd2 && f_in_ready;
  wire [8:0]  woff = `MBR_WDAT_POS + {el, 1'b0};
  wire [15:0] el_nx = {8'h00, el} + 16'h0001;

  // Idle-gap counter; starts empty so a frame needs a full gap after reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gap <= '0;
    end else if (ce) begin
      if (link.m2s_stb) gap <= '0;
      else if (!gap_full) gap <= gap + 24'h000001;
    end
  end

  // Receive: bytes are only taken while idle; a frame not preceded by a
  // full gap is marked bad and thrown away at its end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_len <= '0;
      rx_ovf <= 1'b0;
      rx_bad <= 1'b0;
      rx_crc <= `MBR_CRC_INIT;
    end else if (ce) begin
      if (st == MBR_S_FIN) begin
        rx_len <= '0;
        rx_ovf <= 1'b0;
        rx_bad <= 1'b0;
        rx_crc <= `MBR_CRC_INIT;
      end else if (st == MBR_S_RX && link.m2s_stb) begin
        rx_buf[rx_len] <= link.m2s_data;
        rx_len <= rx_len + 8'h01;
        if (rx_len == 8'hff) rx_ovf <= 1'b1;
        if (link.m2s_err || (rx_len == 8'h00 && !gap_full))
          rx_bad <= 1'b1;
        rx_crc <= mbr_crc_step(rx_crc, link.m2s_data);
      end
    end
  end

  always_comb begin
    next_ecode = 8'h00;
    if (f_fn != `MBR_FN_RD && f_fn != `MBR_FN_WR) begin
      next_ecode = `MBR_EC_FUNC;
    end else if (is_rd) begin
      if (rx_len != `MBR_RD_LEN || f_cnt == 16'h0000 ||
          f_cnt > `MBR_RD_MAX)
        next_ecode = `MBR_EC_DATA;
      else if (f_end > 17'h10000)
        next_ecode = `MBR_EC_ADDR;
      else if (op_forbid || (log_run && f_sa <= `MBR_LOG_HI &&
               f_end[15:0] - 16'h0001 >= `MBR_LOG_LO))
        next_ecode = `MBR_EC_OPER;
    end else begin
      if ({1'b0, rx_len} != `MBR_WR_OVH + {1'b0, f_bc} ||
          {8'h00, f_bc} != {f_cnt[14:0], 1'b0} ||
          f_cnt == 16'h0000 || f_cnt > `MBR_WR_MAX)
        next_ecode = `MBR_EC_DATA;
      else if (f_end > 17'h10000)
        next_ecode = `MBR_EC_ADDR;
      else if (op_forbid)
        next_ecode = `MBR_EC_OPER;
    end
  end

  always_comb begin
    rb    = rx_buf[idx[7:0]];
    rb_ok = 1'b1;
    if (idx == 9'd0) rb = f_adr;
    else if (idx == 9'd1)
      rb = (ecode != 8'h00) ? (f_fn | `MBR_EXC_FLAG) : f_fn;
    else if (idx == rsp_len) rb = tx_crc[7:0];
    else if (idx == rsp_len + 9'd1) rb = tx_crc[15:8];
    else if (ecode != 8'h00) rb = ecode;
    else if (is_rd && idx == 9'd2) rb = {f_cnt[6:0], 1'b0};
    else if (is_rd) begin
      rb    = idx[0] ? rd_word[15:8] : rd_word[7:0];
      rb_ok = word_ok;
    end
  end

  // Command sequencing and the parameter store port
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st         <= MBR_S_RX;
      ecode      <= '0;
      el         <= '0;
      idx        <= '0;
      tx_crc     <= `MBR_CRC_INIT;
      rd_word    <= '0;
      word_ok    <= 1'b0;
      rd_w       <= 1'b0;
      par_addr   <= '0;
      par_wdata  <= '0;
      par_rd     <= 1'b0;
      par_chk    <= 1'b0;
      par_wr     <= 1'b0;
      nvm_commit <= 1'b0;
    end else if (ce) begin
      par_rd     <= 1'b0;
      nvm_commit <= 1'b0;
      rd_w       <= par_rd;
      unique case (st)
        MBR_S_RX: begin
          idx     <= '0;
          el      <= '0;
          word_ok <= 1'b0;
          tx_crc  <= `MBR_CRC_INIT;
          if (frame_end) st <= MBR_S_CHK;
        end
        MBR_S_CHK: begin
          ecode <= next_ecode;
          if (drop) st <= MBR_S_FIN;
          else if (next_ecode == 8'h00 && !is_rd) begin
            par_addr  <= f_sa;
            par_wdata <= {rx_buf[7], rx_buf[8]};
            par_chk   <= 1'b1;
            st        <= MBR_S_WCHK;
          end else st <= MBR_S_RESP;
        end
        MBR_S_WCHK: begin
          // Every value is judged before any is written
          if (!par_ok) begin
            ecode   <= `MBR_EC_DATA;
            par_chk <= 1'b0;
            st      <= MBR_S_RESP;
          end else if (el_nx == f_cnt) begin
            par_chk   <= 1'b0;
            par_wr    <= 1'b1;
            el        <= '0;
            par_addr  <= f_sa;
            par_wdata <= {rx_buf[7], rx_buf[8]};
            st        <= MBR_S_WR;
          end else begin
            el        <= el + 8'h01;
            par_addr  <= par_addr + 16'h0001;
            par_wdata <= {rx_buf[woff[7:0] + 8'h02],
                          rx_buf[woff[7:0] + 8'h03]};
          end
        end
        MBR_S_WR: begin
          if (el_nx == f_cnt) begin
            par_wr     <= 1'b0;
            nvm_commit <= 1'b1;
            st         <= MBR_S_RESP;
          end else begin
            el        <= el + 8'h01;
            par_addr  <= par_addr + 16'h0001;
            par_wdata <= {rx_buf[woff[7:0] + 8'h02],
                          rx_buf[woff[7:0] + 8'h03]};
          end
        end
        MBR_S_RESP: begin
          if (bcast) st <= MBR_S_FIN;
          // Fetch for the high byte only, never past the last data byte
          if (!bcast && is_rd && ecode == 8'h00 && idx >= 9'd3 &&
              idx < rsp_len && idx[0] && !word_ok && !par_rd &&
              !rd_w) begin
            par_rd   <= 1'b1;
            par_addr <= f_sa + {7'h00, idx - 9'd3} / 16'h0002;
          end
          if (rd_w) begin
            rd_word <= par_rdata;
            word_ok <= 1'b1;
          end
          if (push) begin
            idx <= idx + 9'd1;
            if (idx < rsp_len) tx_crc <= mbr_crc_step(tx_crc, rb);
            if (is_rd && idx >= 9'd3 && !idx[0]) word_ok <= 1'b0;
            if (idx == rsp_len + 9'd1) st <= MBR_S_FIN;
          end
        end
        MBR_S_FIN: st <= MBR_S_RX;
      endcase
    end
  end

  // Deferred-class settings are copied to live use only by this pulse,
  // given once after each reset release
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rel_done   <= 1'b0;
      cfg_reload <= 1'b0;
    end else if (ce) begin
      rel_done   <= 1'b1;
      cfg_reload <= !rel_done;
    end
  end

  // Transmit pacing: one character per character time
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt        <= '0;
      link.s2m_stb  <= 1'b0;
      link.s2m_data <= '0;
    end else if (ce) begin
      link.s2m_stb <= 1'b0;
      if (tx_cnt != 24'h000000) tx_cnt <= tx_cnt - 24'h000001;
      else if (f_out_valid) begin
        link.s2m_stb  <= 1'b1;
        link.s2m_data <= f_out_data;
        tx_cnt        <= 24'(CHAR_CYC - 1);
      end
    end
  end

  mbr_fifo #(.W(8), .D(FIFO_DEPTH)) u_txq (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (rb),
    .out_valid (f_out_valid),
    .out_ready (tx_cnt == 24'h000000),
    .out_data  (f_out_data)
  );
endmodule // mbr_slave

`default_nettype wire

//--- hdl/mbr_master.sv
/*
  Host master end: sends user frame bytes with gap and CRC, collects reply.
  Assumes the user offers frame bytes without CRC, ending with usr_last.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mbr_defs.svh"

module mbr_master import mbr_pkg::*; #(
  parameter int CHAR_CYC = `MBR_CHAR_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  mbr_link_if.master       link,
  input  wire logic        usr_valid,
  input  wire logic [7:0]  usr_data,
  input  wire logic        usr_last,
  input  wire logic        usr_err,
  output logic             usr_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_done,
  output logic             rsp_crc_ok
);
  localparam int T35 = (`MBR_GAP_HALFS * CHAR_CYC + 1) / 2;
  if (CHAR_CYC < 2 || T35 >= (1 << 24)) begin : g_bad_char
    $error("mbr_master CHAR_CYC out of range");
  end

  mbr_ms_state_type st;
  logic [23:0] idle;
  logic [23:0] tx_cnt;
  mbr_crc_type tx_crc;
  mbr_crc_type rx_crc;
  logic [8:0]  rx_cnt;
  wire         gap_full = idle == 24'(T35);
  wire         take = usr_valid && usr_ready;

  // Line idle time, restarted by a character in either direction
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idle <= '0;
    end else if (ce) begin
      if (link.m2s_stb || link.s2m_stb) idle <= '0;
      else if (!gap_full) idle <= idle + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st            <= MBR_M_IDLE;
      tx_cnt        <= '0;
      tx_crc        <= `MBR_CRC_INIT;
      usr_ready     <= 1'b0;
      link.m2s_stb  <= 1'b0;
      link.m2s_data <= '0;
      link.m2s_err  <= 1'b0;
    end else if (ce) begin
      link.m2s_stb <= 1'b0;
      link.m2s_err <= 1'b0;
      if (tx_cnt != 24'h000000) tx_cnt <= tx_cnt - 24'h000001;
      unique case (st)
        MBR_M_IDLE, MBR_M_SEND: begin
          if (take) begin
            usr_ready     <= 1'b0;
            link.m2s_stb  <= 1'b1;
            link.m2s_data <= usr_data;
            link.m2s_err  <= usr_err;
            tx_crc        <= mbr_crc_step(tx_crc, usr_data);
            tx_cnt        <= 24'(CHAR_CYC - 1);
            st            <= usr_last ? MBR_M_CRCL : MBR_M_SEND;
          end else if (tx_cnt == 24'h000000 &&
                       (st == MBR_M_SEND || gap_full)) begin
            usr_ready <= 1'b1;
          end
        end
        MBR_M_CRCL: begin
          if (tx_cnt == 24'h000000) begin
            link.m2s_stb  <= 1'b1;
            link.m2s_data <= tx_crc[7:0];
            tx_cnt        <= 24'(CHAR_CYC - 1);
            st            <= MBR_M_CRCH;
          end
        end
        MBR_M_CRCH: begin
          if (tx_cnt == 24'h000000) begin
            link.m2s_stb  <= 1'b1;
            link.m2s_data <= tx_crc[15:8];
            tx_crc        <= `MBR_CRC_INIT;
            st            <= MBR_M_IDLE;
          end
        end
      endcase
    end
  end

  // Reply collection; the reply ends at a full idle gap
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_cnt     <= '0;
      rx_crc     <= `MBR_CRC_INIT;
      rsp_valid  <= 1'b0;
      rsp_data   <= '0;
      rsp_done   <= 1'b0;
      rsp_crc_ok <= 1'b0;
    end else if (ce) begin
      rsp_valid <= link.s2m_stb;
      rsp_done  <= 1'b0;
      if (link.s2m_stb) begin
        rsp_data <= link.s2m_data;
        rx_crc   <= mbr_crc_step(rx_crc, link.s2m_data);
        if (rx_cnt != 9'h1ff) rx_cnt <= rx_cnt + 9'd1;
      end else if (gap_full && rx_cnt != 9'd0) begin
        rsp_done   <= 1'b1;
        rsp_crc_ok <= rx_crc == 16'h0000 && rx_cnt >= 9'd4;
        rx_cnt     <= '0;
        rx_crc     <= `MBR_CRC_INIT;
      end
    end
  end
endmodule // mbr_master

`default_nettype wire

//--- sim/mbr_link_monitor.sv
/*
  Link checker: watches the character strobes between both ends.
  Assumes one clock, async active-low reset, CHAR_CYC as in the design.
*/
`timescale 1ns/1ps
`default_nettype none

module mbr_link_monitor #(
  parameter int CHAR_CYC = 8
) (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       m2s_stb,
  input wire logic [7:0] m2s_data,
  input wire logic       m2s_err,
  input wire logic       s2m_stb,
  input wire logic [7:0] s2m_data
);
  localparam int T35 = (7 * CHAR_CYC + 1) / 2;
  int          m_cnt;
  int          s_cnt;
  int          m_n;
  int          s_idx;
  logic [15:0] m_crc;
  logic [15:0] s_crc;
  logic [7:0]  cmd_addr;
  logic [7:0]  cmd_fn;
  logic [7:0]  rsp_fn;
  logic        bad;
  logic        m_first;

  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction

  // Counters saturate so a long idle line reads as a full gap
  assign m_first = m2s_stb && m_cnt >= T35;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      m_cnt <= 1023;
      m_n <= 0;
      m_crc <= 16'hffff;
      cmd_addr <= 8'h00;
      cmd_fn <= 8'h00;
      bad <= 1'b0;
    end else if (m2s_stb) begin
      m_cnt <= 1;
      m_n <= m_first ? 1 : m_n + 1;
      m_crc <= crc_upd(m_first ? 16'hffff : m_crc, m2s_data);
      if (m_first) cmd_addr <= m2s_data;
      if (!m_first && m_n == 1) cmd_fn <= m2s_data;
      bad <= m2s_err || (bad && !m_first);
    end else if (m_cnt < 1023) begin
      m_cnt <= m_cnt + 1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_cnt <= 1023;
      s_idx <= 0;
      s_crc <= 16'hffff;
      rsp_fn <= 8'h00;
    end else begin
      if (m2s_stb) s_idx <= 0;
      else if (s2m_stb) s_idx <= s_idx + 1;
      if (s2m_stb) begin
        s_cnt <= 1;
        s_crc <= crc_upd(s_idx == 0 ? 16'hffff : s_crc, s2m_data);
        if (s_idx == 1) rsp_fn <= s2m_data;
      end else if (s_cnt < 1023) begin
        s_cnt <= s_cnt + 1;
      end
    end
  end

  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_reply_gap: assert property (s2m_stb |-> m_cnt >= T35)
    else $error("reply began before the idle gap");
  a_reply_pace: assert property (s2m_stb && s_idx != 0 |->
    s_cnt >= CHAR_CYC && s_cnt < T35)
    else $error("reply characters badly spaced");
  a_master_pace: assert property (m2s_stb |->
    m_cnt >= CHAR_CYC && s_cnt >= T35)
    else $error("command character too early");
  a_reply_addr: assert property (s2m_stb && s_idx == 0 |->
    s2m_data == cmd_addr)
    else $error("reply address differs from command");
  a_bcast_silent: assert property (s2m_stb |-> cmd_addr != 8'h00)
    else $error("reply to a broadcast frame");
  a_discard_err: assert property (s2m_stb |-> !bad)
    else $error("reply to a frame with a line error");
  a_reply_func: assert property (s2m_stb && s_idx == 1 |->
    s2m_data == cmd_fn || s2m_data == (cmd_fn | 8'h80))
    else $error("reply function code wrong");
  a_exc_code: assert property (s2m_stb && s_idx == 2 && rsp_fn[7] |->
    s2m_data >= 8'h01 && s2m_data <= 8'h04)
    else $error("exception code out of range");
  a_exc_len: assert property (s2m_stb && rsp_fn[7] |-> s_idx <= 4)
    else $error("exception reply too long");
  a_tx_crc: assert property (m_cnt == T35 && m_n != 0 |->
    m_crc == 16'h0000)
    else $error("command check code wrong");
  a_rx_crc: assert property (s_cnt == T35 && s_idx != 0 |->
    s_crc == 16'h0000)
    else $error("reply check code wrong");
endmodule // mbr_link_monitor

`default_nettype wire

//--- sim/testbench.sv
/*
  Testbench: master and slave joined by the link, store model on the side.
  Assumes the design files and mbr_link_monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int CC = 8;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        usr_valid = 1'b0;
  logic        usr_last = 1'b0;
  logic        usr_err = 1'b0;
  logic        op_forbid = 1'b0;
  logic        log_run = 1'b0;
  logic [7:0]  usr_data = 8'h00;
  logic [15:0] par_rdata = 16'h0000;
  logic        par_ok;
  logic [7:0]  rsp_data;
  logic [15:0] par_addr;
  logic [15:0] par_wdata;
  logic        usr_ready, rsp_valid, rsp_done, rsp_crc_ok;
  logic        par_rd, par_chk, par_wr, nvm_commit, cfg_reload;
  int          failures = 0;
  int          cmp_count = 0;
  int          done_n = 0;
  int          commit_n = 0;
  int          reload_n = 0;
  int          chk_n = 0;
  logic [7:0]  rq[$];
  logic [7:0]  none[$];
  logic [31:0] wq[$];

  mbr_link_if link ();
  mbr_master #(.CHAR_CYC(CC)) mbr_master_inst (.sys_clk, .nrst, .ce,
    .link(link.master), .usr_valid, .usr_data, .usr_last, .usr_err,
    .usr_ready, .rsp_valid, .rsp_data, .rsp_done, .rsp_crc_ok);
  mbr_slave #(.CHAR_CYC(CC), .FIFO_DEPTH(8)) mbr_slave_inst (.sys_clk,
    .nrst, .ce, .link(link.slave), .unit_no(8'h05), .op_forbid,
    .log_run, .par_rdata, .par_ok, .par_addr, .par_wdata, .par_rd, .par_chk,
    .par_wr, .nvm_commit, .cfg_reload);
  mbr_link_monitor #(.CHAR_CYC(CC)) mbr_link_monitor_inst (.sys_clk, .nrst,
    .m2s_stb(link.m2s_stb), .m2s_data(link.m2s_data),
    .m2s_err(link.m2s_err), .s2m_stb(link.s2m_stb),
    .s2m_data(link.s2m_data));

  always #2.5 sys_clk = ~sys_clk;
  // Store rejects only ffff, so one value exercises the range check
  assign par_ok = par_wdata !== 16'hffff;

  always @(posedge sys_clk) begin
    par_rdata <= par_addr ^ 16'ha5c3;
    if (rsp_valid) rq.push_back(rsp_data);
    if (par_wr) wq.push_back({par_addr, par_wdata});
    done_n = done_n + rsp_done;
    commit_n = commit_n + nvm_commit;
    reload_n = reload_n + cfg_reload;
    chk_n = chk_n + par_chk;
  end

  task check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task finish_test;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Sends one frame without check code, then judges the reply
  task run(input logic [7:0] f[$], input logic [7:0] e[$], input bit want,
           input int err_at);
    int n;
    int d;
    n = 0;
    d = done_n;
    rq.delete();
    wq.delete();
    commit_n = 0;
    chk_n = 0;
    foreach (f[i]) begin
      usr_valid <= 1'b1;
      usr_data <= f[i];
      usr_last <= (i == f.size() - 1);
      usr_err <= (i == err_at);
      do begin @(posedge sys_clk); n++; end while (!usr_ready && n < 6000);
    end
    usr_valid <= 1'b0;
    usr_err <= 1'b0;
    if (want) while (done_n == d && n < 6000) begin
      @(posedge sys_clk);
      n++;
    end
    else repeat (400) @(posedge sys_clk);
    if (n >= 6000) begin
      failures++;
      finish_test;
    end
    check("reply length", rq.size(), e.size() + (want ? 2 : 0));
    foreach (e[i]) check("reply byte", rq[i], e[i]);
    if (want) check("reply crc", rsp_crc_ok, 1'b1);
  endtask

  task s_read(input logic [15:0] a0, input logic [15:0] cnt);
    logic [15:0] d;
    logic [7:0]  e[$];
    e = '{8'h05, 8'h03, cnt[6:0] * 8'h02};
    for (int i = 0; i < cnt; i++) begin
      d = 16'(a0 + i) ^ 16'ha5c3;
      e.push_back(d[15:8]);
      e.push_back(d[7:0]);
    end
    run('{8'h05, 8'h03, a0[15:8], a0[7:0], cnt[15:8], cnt[7:0]}, e, 1'b1,
        -1);
    check("store writes", wq.size() + commit_n, 0);
  endtask

  task s_read_errs;
    run('{8'h05, 8'h03, 8'hff, 8'h84, 8'h00, 8'h7d},
        '{8'h05, 8'h83, 8'h02}, 1'b1, -1);
    run('{8'h05, 8'h03, 8'h10, 8'h00, 8'h00, 8'h7e},
        '{8'h05, 8'h83, 8'h03}, 1'b1, -1);
    op_forbid <= 1'b1;
    run('{8'h05, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01},
        '{8'h05, 8'h83, 8'h04}, 1'b1, -1);
    op_forbid <= 1'b0;
    log_run <= 1'b1;
    run('{8'h05, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01},
        '{8'h05, 8'h83, 8'h04}, 1'b1, -1);
    log_run <= 1'b0;
    run('{8'h05, 8'h07, 8'h00, 8'h00}, '{8'h05, 8'h87, 8'h01}, 1'b1,
        -1);
  endtask

  task s_write;
    run('{8'h05, 8'h10, 8'h02, 8'h00, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34,
          8'h56, 8'h78}, '{8'h05, 8'h10, 8'h02, 8'h00, 8'h00, 8'h02},
        1'b1, -1);
    check("write count", wq.size(), 2);
    check("first write", wq[0], 32'h0200_1234);
    check("second write", wq[1], 32'h0201_5678);
    check("commit pulses", commit_n, 1);
    check("range checks", chk_n, 2);
  endtask

  task s_write_errs;
    run('{8'h05, 8'h10, 8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 8'hff, 8'hff},
        '{8'h05, 8'h90, 8'h03}, 1'b1, -1);
    check("rejected writes", wq.size() + commit_n, 0);
    run('{8'h05, 8'h10, 8'h02, 8'h00, 8'h00, 8'h02, 8'h03, 8'h12, 8'h34,
          8'h56}, '{8'h05, 8'h90, 8'h03}, 1'b1, -1);
  endtask

  task s_silent;
    run('{8'h00, 8'h10, 8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h07},
        none, 1'b0, -1);
    check("broadcast writes", wq.size(), 1);
    run('{8'h06, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01}, none, 1'b0,
        -1);
    run('{8'h05, 8'h03, 8'h10, 8'h00, 8'h00, 8'h01}, none, 1'b0,
        2);
  endtask

  // Reset released while frozen: reload waits for the first enabled cycle
  task s_reset;
    ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    check("reload while frozen", reload_n, 1);
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("reload after reset", reload_n, 2);
    s_read(16'h0010, 16'h0001);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    s_read(16'h1000, 16'h0002);
    s_read(16'hff83, 16'h007d);
    s_read_errs;
    s_write;
    s_write_errs;
    s_silent;
    check("reload pulses", reload_n, 1);
    s_reset;
    finish_test;
  end
endmodule // testbench

`default_nettype wire
